// [pdrs_pkg.sv]
package pdrs_pkg;

  // Clock and supply settling timing.
  localparam int unsigned CLK_PERIOD_NS    = 5;
  localparam int unsigned SUPPLY_SETTLE_NS = 100;
  localparam int unsigned SETTLE_CYC_RAW   =
    (SUPPLY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETTLE_CYC       = (SETTLE_CYC_RAW < 1) ? 1 : SETTLE_CYC_RAW;
  localparam int unsigned CNT_W            = 8;

  // Reset signal levels, active low.
  localparam logic RST_ON  = 1'b0;
  localparam logic RST_OFF = 1'b1;

  // Regulator enable levels.
  localparam logic REG_OFF = 1'b0;
  localparam logic REG_ON  = 1'b1;

  // Power-up flag levels.
  localparam logic FLAG_SET = 1'b1;
  localparam logic FLAG_CLR = 1'b0;

  // Power reset stages, ordered by priority.
  localparam int unsigned STG_POR  = 0;
  localparam int unsigned STG_SBC  = 1;
  localparam int unsigned STG_CORE = 2;
  localparam int unsigned STG_N    = 3;

  // Supply monitor flag positions.
  localparam int unsigned SUP_PAD_BACKUP = 0;
  localparam int unsigned SUP_PAD        = 1;
  localparam int unsigned SUP_STANDBY    = 2;
  localparam int unsigned SUP_CORE       = 3;
  localparam int unsigned SUP_N          = 4;

  // Core-voltage domains that carry user-class resets.
  localparam int unsigned DOM_STANDBY = 0;
  localparam int unsigned DOM_CORE    = 1;
  localparam int unsigned DOM_N       = 2;

  // Sequencer states.
  typedef enum logic [2:0] {
    ST_POR       = 3'h0,
    ST_STBY_RAMP = 3'h1,
    ST_SBC_ACT   = 3'h2,
    ST_CORE_RAMP = 3'h3,
    ST_CORE_ACT  = 3'h4,
    ST_RUN       = 3'h5
  } pdrs_state_e;

endpackage

// [pdrs_rst_sync.sv]
`timescale 1ns/100ps
// Asserts asynchronously, releases after two clock edges.
module pdrs_rst_sync (
  // Clock
  input  wire logic clk_i,
  // Asynchronous reset source
  input  wire logic arst_n_i,
  // Reset with synchronous release
  output logic      rst_n_o
);

  logic meta_ff;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_ff <= 1'b0;
      rst_n_o <= 1'b0;
    end else begin
      meta_ff <= 1'b1;
      rst_n_o <= meta_ff;
    end
  end

endmodule

// [pdrs_sync2.sv]
`timescale 1ns/100ps
module pdrs_sync2 #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // Level inputs and their synchronised copies
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_ff;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_ff <= '0;
      q_o     <= '0;
    end else begin
      meta_ff <= d_i;
      q_o     <= meta_ff;
    end
  end

endmodule

// [pdrs_top.sv]
`timescale 1ns/100ps
// Summary of operation
// (RQ1) Each supply domain gets its own power reset; core domains also get user resets.
// (RQ2) Priority: power-on, standby-plus-core, core-only, internal application, application.
// (RQ3) An active reset also activates every lower-priority reset.
// (RQ4) Backup logic ramps standby supply and watches pad-backup and standby supplies.
// (RQ5) Standby logic ramps the core supply and supervises its level.
// (RQ6) Power-on reset clears every storage element at once, in any state.
// (RQ7) Power-on reset disables core-voltage supplies while the pad reset is active.
// (RQ8) Pin low triggers power-on reset with no arbitration and no disable.
// (RQ9) Backup reset stays active while the pin is low.
// (RQ10) After pin release start standby supply, await levels, then standby-plus-core flow.
// (RQ11) Watchdog expiry or clock failure also raise power-on reset.
// (RQ12) Checker fault or pad supply drop requests the standby-plus-core reset.
// (RQ13) Standby-plus-core reset resets both standby and core domains.
// (RQ14) During standby-plus-core reset core regulator is off, standby regulator on.
// (RQ15) Standby domain enters its reset phase at once on any enabled trigger.
// (RQ16) After the standby phase, start core supply, await level, run core-only flow.
// (RQ17) Standby-plus-core reset leaves the backup power-up flag untouched.
// (RQ18) Core-only reset enters at once; leaves when supply valid and trigger gone.
// (RQ19) Power resets act asynchronously without needing a running clock.
module pdrs_top
  import pdrs_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = SETTLE_CYC
) (
  // Clock and reset
  input  wire logic             CORE_CLK_I,
  input  wire logic             RESET_N_I,
  // External power-on reset pin
  input  wire logic             POWER_ON_RESET_PIN_N_I,
  // Hardware exception triggers
  input  wire logic             WATCHDOG_TIMER_EXPIRY_I,
  input  wire logic             CLOCK_FAIL_I,
  // Supply fault triggers and their enables
  input  wire logic             SUPPLY_VOLTAGE_CHECKER_FAULT_I,
  input  wire logic             SUPPLY_VOLTAGE_CHECKER_EN_I,
  input  wire logic             PAD_SUPPLY_DROP_I,
  input  wire logic             PAD_SUPPLY_DROP_EN_I,
  // Core-only reset trigger from the standby domain
  input  wire logic             CORE_DOMAIN_TRIG_I,
  // Supply level monitors, high while in range
  input  wire logic             PAD_BACKUP_SUPPLY_OK_I,
  input  wire logic             PAD_SUPPLY_OK_I,
  input  wire logic             STANDBY_CORE_SUPPLY_OK_I,
  input  wire logic             CORE_DOMAIN_SUPPLY_OK_I,
  // User reset requests from the reset control logic
  input  wire logic             INT_APP_RST_REQ_I,
  input  wire logic             APP_RST_REQ_I,
  // Power-up flag clear
  input  wire logic             POR_FLAG_CLR_I,
  // Domain power resets
  output logic                  BACKUP_DOMAIN_RST_N_O,
  output logic                  STANDBY_DOMAIN_RST_N_O,
  output logic                  CORE_DOMAIN_RST_N_O,
  // User resets, index 0 standby domain, index 1 core domain
  output logic [DOM_N-1:0]      INT_APP_RST_N_O,
  output logic [DOM_N-1:0]      APP_RST_N_O,
  // Regulator enables
  output logic                  STANDBY_REGULATOR_EN_O,
  output logic                  CORE_REGULATOR_EN_O,
  // Power-up flag of the backup domain
  output logic                  POWER_ON_FLAG_O
);

  logic [STG_N-1:0] src_n;
  logic [STG_N-1:0] stg_n_s;
  logic             por_n_s;
  logic             sbc_n_s;
  logic             core_n_s;
  logic [SUP_N-1:0] sup_raw;
  logic [SUP_N-1:0] sup_ok_s;
  logic             stby_ready;
  logic             core_ok;
  logic             settled;
  pdrs_state_e      state_ff;
  pdrs_state_e      nxt_state;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic             user_run;

  // (RQ8) Pin trigger, unconditional.
  // (RQ11) Hardware exceptions escalate.
  assign src_n[STG_POR] = RESET_N_I & POWER_ON_RESET_PIN_N_I
                        & ~WATCHDOG_TIMER_EXPIRY_I & ~CLOCK_FAIL_I;

  // (RQ12) Enabled supply faults.
  // (RQ2) Higher stages feed lower.
  assign src_n[STG_SBC] = src_n[STG_POR]
                        & ~(SUPPLY_VOLTAGE_CHECKER_FAULT_I & SUPPLY_VOLTAGE_CHECKER_EN_I)
                        & ~(PAD_SUPPLY_DROP_I & PAD_SUPPLY_DROP_EN_I);

  // (RQ18) Core-only trigger, no arbitration.
  // (RQ3) Cascade into lower stages.
  assign src_n[STG_CORE] = src_n[STG_SBC] & ~CORE_DOMAIN_TRIG_I;

  // (RQ19) Asynchronous assertion per stage.
  // (RQ15) Immediate entry on trigger.
  for (genvar g = 0; g < STG_N; g++) begin : g_stage
    pdrs_rst_sync u_rst_sync (
      .clk_i    (CORE_CLK_I),
      .arst_n_i (src_n[g]),
      .rst_n_o  (stg_n_s[g])
    );
  end

  assign por_n_s  = stg_n_s[STG_POR];
  assign sbc_n_s  = stg_n_s[STG_SBC];
  assign core_n_s = stg_n_s[STG_CORE];

  assign sup_raw[SUP_PAD_BACKUP] = PAD_BACKUP_SUPPLY_OK_I;
  assign sup_raw[SUP_PAD]        = PAD_SUPPLY_OK_I;
  assign sup_raw[SUP_STANDBY]    = STANDBY_CORE_SUPPLY_OK_I;
  assign sup_raw[SUP_CORE]       = CORE_DOMAIN_SUPPLY_OK_I;

  pdrs_sync2 #(
    .W (SUP_N)
  ) u_sup_sync (
    .clk_i   (CORE_CLK_I),
    .rst_n_i (por_n_s),
    .d_i     (sup_raw),
    .q_o     (sup_ok_s)
  );

  // (RQ4) Backup-domain supply watch.
  assign stby_ready = sup_ok_s[SUP_PAD_BACKUP] & sup_ok_s[SUP_PAD]
                    & sup_ok_s[SUP_STANDBY];
  // (RQ5) Core supply supervision.
  assign core_ok    = sup_ok_s[SUP_CORE];
  assign settled    = (cnt_ff == CNT_W'(SETTLE_CYCLES - 1));

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = '0;
    unique case (state_ff)
      // (RQ10) Start standby supply after pin release.
      ST_POR: begin
        nxt_state = ST_STBY_RAMP;
      end
      // (RQ10) Wait for pad and standby levels.
      ST_STBY_RAMP: begin
        if (stby_ready) begin
          if (settled) begin
            nxt_state = ST_SBC_ACT;
          end else begin
            nxt_cnt = cnt_ff + CNT_W'(1);
          end
        end
      end
      ST_SBC_ACT: begin
        if (sbc_n_s && stby_ready) begin
          nxt_state = ST_CORE_RAMP;
        end
      end
      // (RQ16) Ramp core supply and await level.
      ST_CORE_RAMP: begin
        if (!stby_ready) begin
          nxt_state = ST_SBC_ACT;
        end else if (core_ok) begin
          if (settled) begin
            nxt_state = ST_CORE_ACT;
          end else begin
            nxt_cnt = cnt_ff + CNT_W'(1);
          end
        end
      end
      // (RQ18) Leave once supply valid and trigger released.
      ST_CORE_ACT: begin
        if (!stby_ready) begin
          nxt_state = ST_SBC_ACT;
        end else if (core_n_s && core_ok) begin
          nxt_state = ST_RUN;
        end
      end
      // (RQ5) Supply loss in operation escalates.
      ST_RUN: begin
        if (!stby_ready || !core_ok) begin
          nxt_state = ST_SBC_ACT;
        end else if (!core_n_s) begin
          nxt_state = ST_CORE_ACT;
        end
      end
      default: begin
        nxt_state = ST_POR;
      end
    endcase
    if (!sbc_n_s && state_ff != ST_POR && state_ff != ST_STBY_RAMP) begin
      nxt_state = ST_SBC_ACT;
      nxt_cnt   = '0;
    end
  end

  // (RQ6) Power-on reset clears sequencer state.
  always_ff @(posedge CORE_CLK_I or negedge por_n_s) begin
    if (!por_n_s) begin
      state_ff <= ST_POR;
      cnt_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // (RQ9) Backup reset follows the pin.
  always_ff @(posedge CORE_CLK_I or negedge por_n_s) begin
    if (!por_n_s) begin
      BACKUP_DOMAIN_RST_N_O <= RST_ON;
    end else begin
      BACKUP_DOMAIN_RST_N_O <= RST_OFF;
    end
  end

  // (RQ7) Core-voltage supplies off during power-on reset.
  always_ff @(posedge CORE_CLK_I or negedge por_n_s) begin
    if (!por_n_s) begin
      STANDBY_REGULATOR_EN_O <= REG_OFF;
    end else begin
      STANDBY_REGULATOR_EN_O <= (nxt_state != ST_POR);
    end
  end

  // (RQ13) Standby reset from the standby-plus-core stage, released when the core ramp starts.
  always_ff @(posedge CORE_CLK_I or negedge sbc_n_s) begin
    if (!sbc_n_s) begin
      STANDBY_DOMAIN_RST_N_O <= RST_ON;
    end else begin
      STANDBY_DOMAIN_RST_N_O <= (nxt_state == ST_CORE_RAMP) || (nxt_state == ST_CORE_ACT)
                                || (nxt_state == ST_RUN);
    end
  end

  // (RQ14) Core regulator off in standby-plus-core phase.
  always_ff @(posedge CORE_CLK_I or negedge sbc_n_s) begin
    if (!sbc_n_s) begin
      CORE_REGULATOR_EN_O <= REG_OFF;
    end else begin
      CORE_REGULATOR_EN_O <= (nxt_state == ST_CORE_RAMP) || (nxt_state == ST_RUN)
                             || ((nxt_state == ST_CORE_ACT) && core_n_s);
    end
  end

  // (RQ18) Core reset released only in operation.
  always_ff @(posedge CORE_CLK_I or negedge core_n_s) begin
    if (!core_n_s) begin
      CORE_DOMAIN_RST_N_O <= RST_ON;
    end else begin
      CORE_DOMAIN_RST_N_O <= (nxt_state == ST_RUN);
    end
  end

  assign user_run = (nxt_state == ST_RUN);

  // (RQ1) User resets for both core-voltage domains.
  // (RQ3) Power resets and internal application reset cascade down.
  for (genvar d = 0; d < DOM_N; d++) begin : g_user
    always_ff @(posedge CORE_CLK_I or negedge core_n_s) begin
      if (!core_n_s) begin
        INT_APP_RST_N_O[d] <= RST_ON;
        APP_RST_N_O[d]     <= RST_ON;
      end else begin
        INT_APP_RST_N_O[d] <= user_run & ~INT_APP_RST_REQ_I;
        APP_RST_N_O[d]     <= user_run & ~INT_APP_RST_REQ_I & ~APP_RST_REQ_I;
      end
    end
  end

  // (RQ17) Flag set only by power-on reset.
  always_ff @(posedge CORE_CLK_I or negedge por_n_s) begin
    if (!por_n_s) begin
      POWER_ON_FLAG_O <= FLAG_SET;
    end else if (POR_FLAG_CLR_I) begin
      POWER_ON_FLAG_O <= FLAG_CLR;
    end
  end

  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!RESET_N_I);

  chk_por_clears_all: assert property ( // RQ6
    !por_n_s |-> (!STANDBY_DOMAIN_RST_N_O && !CORE_DOMAIN_RST_N_O
                  && !STANDBY_REGULATOR_EN_O && !CORE_REGULATOR_EN_O
                  && !BACKUP_DOMAIN_RST_N_O && POWER_ON_FLAG_O))
    else $error("power-on reset did not clear all domains");

  chk_cascade_user_rst: assert property ( // RQ3
    !CORE_DOMAIN_RST_N_O |-> (INT_APP_RST_N_O == '0 && APP_RST_N_O == '0))
    else $error("user reset released while core reset active");

  chk_sbc_both_domains: assert property ( // RQ13
    !STANDBY_DOMAIN_RST_N_O |-> !CORE_DOMAIN_RST_N_O)
    else $error("core domain released during standby reset");

  chk_sbc_regulators: assert property ( // RQ14
    (state_ff == ST_SBC_ACT) |-> (!CORE_REGULATOR_EN_O && STANDBY_REGULATOR_EN_O))
    else $error("wrong regulator state in standby-plus-core reset");

  chk_sbc_immediate: assert property ( // RQ15
    !sbc_n_s |-> !STANDBY_DOMAIN_RST_N_O)
    else $error("standby reset not active on trigger");

  chk_por_to_ramp: assert property ( // RQ10
    (state_ff == ST_POR && por_n_s) |=> (state_ff == ST_STBY_RAMP) && STANDBY_REGULATOR_EN_O)
    else $error("standby ramp did not follow power-on release");

  chk_stby_wait_level: assert property ( // RQ10
    (state_ff == ST_STBY_RAMP && !stby_ready) |=> (state_ff == ST_STBY_RAMP))
    else $error("standby ramp left without valid levels");

  chk_core_ramp_start: assert property ( // RQ16
    (state_ff == ST_SBC_ACT && sbc_n_s && stby_ready)
      |=> (state_ff == ST_CORE_RAMP) && CORE_REGULATOR_EN_O)
    else $error("core ramp did not start after standby phase");

  chk_core_exit_cond: assert property ( // RQ18
    $rose(CORE_DOMAIN_RST_N_O) |-> $past(core_ok) && $past(core_n_s))
    else $error("core reset released without valid supply");

  chk_flag_kept: assert property ( // RQ17
    (POWER_ON_FLAG_O && !POR_FLAG_CLR_I && !sbc_n_s) |=> POWER_ON_FLAG_O)
    else $error("power-up flag lost in standby-plus-core reset");

endmodule

// [pdrs_supply_model.sv]
`timescale 1ns/100ps
module pdrs_supply_model #(
  parameter int unsigned RAMP_CYC = 3
) (
  // Clock
  input  wire logic clk_i,
  // Rail sources: pad supply, standby regulator, core regulator
  input  wire logic pad_on_i,
  input  wire logic standby_regulator_en_i,
  input  wire logic core_regulator_en_i,
  // Monitor flags, high while the rail is in range
  output logic      pad_backup_supply_ok_o,
  output logic      pad_supply_ok_o,
  output logic      standby_core_supply_ok_o,
  output logic      core_domain_supply_ok_o
);
  logic [2:0] en;
  logic [2:0] ok;
  logic [7:0] cnt_ff [3];

  assign en = {core_regulator_en_i, standby_regulator_en_i, pad_on_i};
  // pad, standby and core rail ramps.
  // A rail reaches range some cycles after its source turns on and drops at once.
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 3; i++) begin
      if (!en[i]) begin
        cnt_ff[i] <= 8'h00;
      end else if (cnt_ff[i] != 8'(RAMP_CYC)) begin
        cnt_ff[i] <= cnt_ff[i] + 8'h01;
      end
    end
  end
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      ok[i] = en[i] && (cnt_ff[i] == 8'(RAMP_CYC));
    end
  end
  assign pad_backup_supply_ok_o   = ok[0];
  assign pad_supply_ok_o          = ok[0];
  assign standby_core_supply_ok_o = ok[1];
  assign core_domain_supply_ok_o  = ok[2];
endmodule

// [pdrs_top_tb.sv]
`timescale 1ns/100ps
module pdrs_top_tb;
  import pdrs_pkg::*;
  logic       clk = 1'b0, rst_n = 1'b0, pin_n = 1'b0, pad_on = 1'b0;
  logic       wdt = 1'b0, cfail = 1'b0, supply_voltage_checker = 1'b0, pvc_en = 1'b0;
  logic       drop = 1'b0, drop_en = 1'b0, trig = 1'b0;
  logic       iar = 1'b0, ar = 1'b0, fclr = 1'b0;
  logic       pb_ok, pad_ok, sb_ok, co_ok, b_n, s_n, c_n, sreg, creg, flag;
  logic [1:0] ia_n, a_n;
  wire  [9:0] outs = {b_n, s_n, c_n, ia_n, a_n, sreg, creg, flag};
  int         n_errors = 0;
  int         check_count = 0;

  always #2.5 clk = ~clk;

  pdrs_top #(.SETTLE_CYCLES(2)) i_dut (
    .CORE_CLK_I(clk), .RESET_N_I(rst_n), .POWER_ON_RESET_PIN_N_I(pin_n),
    .WATCHDOG_TIMER_EXPIRY_I(wdt), .CLOCK_FAIL_I(cfail),
    .SUPPLY_VOLTAGE_CHECKER_FAULT_I(supply_voltage_checker), .SUPPLY_VOLTAGE_CHECKER_EN_I(pvc_en),
    .PAD_SUPPLY_DROP_I(drop), .PAD_SUPPLY_DROP_EN_I(drop_en),
    .CORE_DOMAIN_TRIG_I(trig), .PAD_BACKUP_SUPPLY_OK_I(pb_ok), .PAD_SUPPLY_OK_I(pad_ok),
    .STANDBY_CORE_SUPPLY_OK_I(sb_ok), .CORE_DOMAIN_SUPPLY_OK_I(co_ok),
    .INT_APP_RST_REQ_I(iar), .APP_RST_REQ_I(ar), .POR_FLAG_CLR_I(fclr),
    .BACKUP_DOMAIN_RST_N_O(b_n), .STANDBY_DOMAIN_RST_N_O(s_n), .CORE_DOMAIN_RST_N_O(c_n),
    .INT_APP_RST_N_O(ia_n), .APP_RST_N_O(a_n), .STANDBY_REGULATOR_EN_O(sreg),
    .CORE_REGULATOR_EN_O(creg), .POWER_ON_FLAG_O(flag));

  pdrs_supply_model i_model (
    .clk_i(clk), .pad_on_i(pad_on), .standby_regulator_en_i(sreg),
    .core_regulator_en_i(creg), .pad_backup_supply_ok_o(pb_ok),
    .pad_supply_ok_o(pad_ok), .standby_core_supply_ok_o(sb_ok),
    .core_domain_supply_ok_o(co_ok));

  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [9:0] exp, input logic [9:0] mask);
    check_count++;
    if ((outs & mask) !== (exp & mask)) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, outs & mask, exp & mask);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Waits, bounded, until every reset and both regulators are released.
  task automatic wait_run();
    for (int n = 0; n < 300 && outs[9:1] !== 9'h1FF; n++) @(negedge clk);
  endtask

  task automatic clear_flag();
    fclr = 1'b1;
    cyc(1);
    fclr = 1'b0;
    cyc(1);
    check(10'h000, 10'h001);
  endtask

  task automatic t_power_on();
    check(10'h001, 10'h3FF);
    rst_n = 1'b1;
    cyc(4);
    check(10'h001, 10'h3FF);
    // pin held until pad supply in range.
    for (int n = 0; n < 50 && pad_ok !== 1'b1; n++) @(negedge clk);
    pin_n = 1'b1;
    cyc(3);
    check(10'h205, 10'h3FF);
    wait_run();
    check(10'h3FF, 10'h3FF);
  endtask

  task automatic t_user();
    iar = 1'b1;
    cyc(1);
    check(10'h386, 10'h3FE);
    iar = 1'b0;
    ar = 1'b1;
    cyc(1);
    check(10'h3E6, 10'h3FE);
    ar = 1'b0;
    cyc(1);
    check(10'h3FE, 10'h3FE);
  endtask

  task automatic set_sbc(input int k, input logic f, input logic e);
    supply_voltage_checker = f && k == 0;
    drop = f && k == 1;
    pvc_en = e && k == 0;
    drop_en = e && k == 1;
  endtask

  task automatic t_sbc();
    clear_flag();
    for (int k = 0; k < 2; k++) begin
      set_sbc(k, 1'b1, 1'b0);
      cyc(4);
      check(10'h3FE, 10'h3FF);
      set_sbc(k, 1'b1, 1'b1);
      #1;
      check(10'h200, 10'h3F8);
      cyc(3);
      check(10'h204, 10'h3FF);
      set_sbc(k, 1'b0, 1'b0);
      wait_run();
      check(10'h3FE, 10'h3FF);
    end
  endtask

  task automatic t_core();
    trig = 1'b1;
    #1;
    check(10'h300, 10'h3F8);
    cyc(3);
    check(10'h304, 10'h3FE);
    trig = 1'b0;
    wait_run();
    check(10'h3FE, 10'h3FF);
  endtask

  // Pad rail loss in operation falls back to the standby-plus-core phase.
  task automatic t_supply();
    pad_on = 1'b0;
    cyc(4);
    check(10'h204, 10'h3FF);
    pad_on = 1'b1;
    wait_run();
    check(10'h3FE, 10'h3FF);
  endtask

  task automatic set_por(input int i, input logic on);
    pin_n = !(on && i == 0);
    wdt = on && i == 1;
    cfail = on && i == 2;
    rst_n = !(on && i == 3);
  endtask

  task automatic t_por();
    for (int i = 0; i < 4; i++) begin
      clear_flag();
      set_por(i, 1'b1);
      #1;
      check(10'h001, 10'h3FF);
      cyc(2);
      check(10'h001, 10'h3FF);
      set_por(i, 1'b0);
      wait_run();
      check(10'h3FF, 10'h3FF);
    end
  endtask

  initial begin
    cyc(1);
    pad_on = 1'b1;
    cyc(9);
    t_power_on();
    t_user();
    t_sbc();
    t_core();
    t_supply();
    t_por();
    give_verdict();
  end

  initial begin
    #50000;
    n_errors++;
    give_verdict();
  end
endmodule
